// [pkg/rsp_defines.vh]
// constants shared by the rtc serial port and its register store
`ifndef RSP_DEFINES_VH
`define RSP_DEFINES_VH

// --------------------------------------------------------------
// register space
// --------------------------------------------------------------
`define RSP_REG_COUNT 32
`define RSP_REG_AW 5
`define RSP_PTR_W 6
`define RSP_CAL_BYTES 8
`define RSP_CAL_LAST 5'h07

// --------------------------------------------------------------
// calendar byte offsets
// --------------------------------------------------------------
`define RSP_OFS_HSEC 0
`define RSP_OFS_SEC 1
`define RSP_OFS_MIN 2
`define RSP_OFS_HOUR 3
`define RSP_OFS_DAY 4
`define RSP_OFS_DATE 5
`define RSP_OFS_MONTH 6
`define RSP_OFS_YEAR 7

// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define RSP_STOP_BIT 7
`define RSP_CMD_WRITE_BIT 7
`define RSP_RST_ZERO 8'h00
`define RSP_RST_ONE 8'h01

// --------------------------------------------------------------
// bcd roll-over points
// --------------------------------------------------------------
`define RSP_HSEC_MAX 8'h99
`define RSP_MINSEC_MAX 7'h59
`define RSP_HOUR_MAX 6'h23
`define RSP_DAY_MAX 3'h7
`define RSP_MONTH_MAX 5'h12
`define RSP_YEAR_MAX 8'h99
`define RSP_MONTH_FEB 5'h02
`define RSP_MONTH_APR 5'h04
`define RSP_MONTH_JUN 5'h06
`define RSP_MONTH_SEP 5'h09
`define RSP_MONTH_NOV 5'h11

`endif

// [core/rsp_reg_store.v]
// 32-byte register store of the real-time clock, flip-flop based
`timescale 1ns/1ns
`include "rsp_defines.vh"

module rsp_reg_store #(
  parameter REG_COUNT = `RSP_REG_COUNT,
  parameter AW = `RSP_REG_AW
)(
  input wire clock, // system clock
  input wire rst_n, // async reset, active low
  input wire clkEn, // freezes all state while low
  input wire wrEn, // serial write of one byte
  input wire [AW-1:0] wrAddr, // byte index of the write
  input wire [7:0] wrData, // byte written
  input wire [AW-1:0] rdAddr, // byte index read
  output wire [7:0] rdData, // byte at rdAddr, straight from the flops
  input wire [`RSP_CAL_BYTES-1:0] calUpd, // calendar byte update strobes
  input wire [8*`RSP_CAL_BYTES-1:0] calNext, // calendar next values
  output wire [8*`RSP_CAL_BYTES-1:0] calView // current calendar bytes
);

  reg [7:0] mem [0:REG_COUNT-1];

  // --------------------------------------------------------------
  // reset values: calendar starts on day, date and month one
  // --------------------------------------------------------------
  function [7:0] resetValue;
    input integer idx;
    begin
      if (idx == `RSP_OFS_DAY || idx == `RSP_OFS_DATE || idx == `RSP_OFS_MONTH) begin
        resetValue = `RSP_RST_ONE;
      end else begin
        resetValue = `RSP_RST_ZERO;
      end
    end
  endfunction

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g = g + 1) begin : gByte
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= resetValue(g);
        end else if (clkEn) begin
          // a software write wins over a same-cycle calendar carry
          if (wrEn && {{(32-AW){1'b0}}, wrAddr} == g) begin
            mem[g] <= wrData;
          end else if (g < `RSP_CAL_BYTES) begin
            if (calUpd[g % `RSP_CAL_BYTES]) begin
              mem[g] <= calNext[(g % `RSP_CAL_BYTES)*8 +: 8];
            end
          end
        end
      end
    end
    for (g = 0; g < `RSP_CAL_BYTES; g = g + 1) begin : gView
      assign calView[g*8 +: 8] = mem[g];
    end
  endgenerate

  assign rdData = mem[rdAddr];

endmodule // rsp_reg_store

// [core/rsp_serial_port.v]
// serial slave port and bcd calendar of the real-time clock
`timescale 1ns/1ns
`include "rsp_defines.vh"

// --------------------------------------------------------------
// --------------------------------------------------------------

module rsp_serial_port #(
  parameter PTR_W = `RSP_PTR_W
)(
  input wire clock, // 20 MHz system clock
  input wire rst_n, // async reset, active low
  input wire clkEn, // freezes all state while low
  input wire hundredthTick, // one-cycle pulse every 10 ms
  input wire serialClock, // bus clock from the master
  input wire chipSelN, // chip select, active low
  input wire serial_in_line, // serial data from the master
  output wire serial_out_line, // serial data to the master
  output wire serialOutEn, // high while serial_out_line is driven
  output wire clockAccess // calendar bytes being accessed at pointer 0-7, not through their aliases at 32-39
);

  // --------------------------------------------------------------
  // port state
  // --------------------------------------------------------------
  reg sclPrev;
  reg selPrev;
  reg armed;
  reg inCmd;
  reg dirWrite;
  reg loadPending;
  reg sdoBit;
  reg sdoEn;
  reg [2:0] bitCnt;
  reg [PTR_W-1:0] ptr;
  reg [6:0] shiftIn;
  reg [7:0] outByte;
  reg next_inCmd;
  reg next_dirWrite;
  reg next_loadPending;
  reg next_sdoBit;
  reg next_sdoEn;
  reg [2:0] next_bitCnt;
  reg [PTR_W-1:0] next_ptr;
  reg [6:0] next_shiftIn;
  reg wrStrobe;
  reg pendTick;

  wire [7:0] rdData;
  wire [7:0] byteIn = {shiftIn, serial_in_line};
  wire [2:0] outIdx = ~bitCnt;
  wire sclRise = serialClock & ~sclPrev;
  wire sclFall = ~serialClock & sclPrev;
  wire selFall = selPrev & ~chipSelN;
  wire armedNow = armed | selFall;

  // --------------------------------------------------------------
  // serial protocol
  // --------------------------------------------------------------
  always @* begin
    next_bitCnt = bitCnt;
    next_inCmd = inCmd;
    next_dirWrite = dirWrite;
    next_ptr = ptr;
    next_shiftIn = shiftIn;
    next_loadPending = 1'b0;
    next_sdoBit = sdoBit;
    next_sdoEn = sdoEn;
    wrStrobe = 1'b0;
    if (chipSelN) begin
      next_bitCnt = 3'h0;
      next_inCmd = 1'b1;
      next_dirWrite = 1'b0;
      next_sdoEn = 1'b0;
    end else if (armedNow) begin
      if (sclRise) begin
        next_shiftIn = byteIn[6:0];
        next_bitCnt = bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          if (inCmd) begin
            next_inCmd = 1'b0;
            next_dirWrite = byteIn[`RSP_CMD_WRITE_BIT];
            // address bit 6 is a don't-care; pointer keeps six bits
            next_ptr = byteIn[PTR_W-1:0];
            next_loadPending = ~byteIn[`RSP_CMD_WRITE_BIT];
          end else begin
            next_ptr = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            wrStrobe = dirWrite;
            next_loadPending = ~dirWrite;
          end
        end
      end
      // a falling edge right after a load takes the fresh byte directly
      if (sclFall && !inCmd && !dirWrite) begin
        next_sdoBit = loadPending ? rdData[outIdx] : outByte[outIdx];
        next_sdoEn = 1'b1;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev <= 1'b0;
      selPrev <= 1'b0;
      armed <= 1'b0;
      inCmd <= 1'b1;
      dirWrite <= 1'b0;
      loadPending <= 1'b0;
      sdoBit <= 1'b0;
      sdoEn <= 1'b0;
      bitCnt <= 3'h0;
      ptr <= {PTR_W{1'b0}};
      shiftIn <= 7'h00;
      outByte <= 8'h00;
    end else if (clkEn) begin
      sclPrev <= serialClock;
      selPrev <= chipSelN;
      if (selFall) begin
        armed <= 1'b1;
      end
      inCmd <= next_inCmd;
      dirWrite <= next_dirWrite;
      loadPending <= next_loadPending;
      sdoBit <= next_sdoBit;
      sdoEn <= next_sdoEn;
      bitCnt <= next_bitCnt;
      ptr <= next_ptr;
      shiftIn <= next_shiftIn;
      if (loadPending) begin
        outByte <= rdData;
      end
    end
  end

  assign serial_out_line = sdoBit;
  assign serialOutEn = sdoEn;
  assign clockAccess = ~chipSelN & armed & ~inCmd &
    (ptr[PTR_W-1:3] == {(PTR_W-3){1'b0}});

  // --------------------------------------------------------------
  // calendar carry chain
  // --------------------------------------------------------------
  function [7:0] bcdInc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcdInc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdInc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  function [5:0] lastDate;
    input [4:0] month;
    input [7:0] year;
    reg leap;
    begin
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6) :
        (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
      if (month == `RSP_MONTH_FEB) begin
        lastDate = leap ? 6'h29 : 6'h28;
      end else if (month == `RSP_MONTH_APR || month == `RSP_MONTH_JUN ||
                   month == `RSP_MONTH_SEP || month == `RSP_MONTH_NOV) begin
        lastDate = 6'h30;
      end else begin
        lastDate = 6'h31;
      end
    end
  endfunction

  wire [8*`RSP_CAL_BYTES-1:0] calView;
  wire [8*`RSP_CAL_BYTES-1:0] incAll;
  reg [8*`RSP_CAL_BYTES-1:0] calNext;
  reg [`RSP_CAL_BYTES-1:0] calUpd;
  reg [7:0] c;
  reg [7:0] w;

  genvar g;
  generate
    for (g = 0; g < `RSP_CAL_BYTES; g = g + 1) begin : gInc
      assign incAll[g*8 +: 8] = bcdInc(calView[g*8 +: 8]);
    end
  endgenerate

  // ticks wait while the master touches calendar bytes at pointer 0-7, so a read there sees one snapshot
  wire tickGo = ~clockAccess & (hundredthTick | pendTick);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pendTick <= 1'b0;
    end else if (clkEn) begin
      if (hundredthTick && clockAccess) begin
        pendTick <= 1'b1;
      end else if (tickGo) begin
        pendTick <= 1'b0;
      end
    end
  end

  always @* begin
    w[0] = calView[7:0] == `RSP_HSEC_MAX;
    w[1] = calView[14:8] == `RSP_MINSEC_MAX;
    w[2] = calView[22:16] == `RSP_MINSEC_MAX;
    w[3] = calView[29:24] == `RSP_HOUR_MAX;
    w[4] = calView[34:32] == `RSP_DAY_MAX;
    w[5] = calView[45:40] == lastDate(calView[52:48], calView[63:56]);
    w[6] = calView[52:48] == `RSP_MONTH_MAX;
    w[7] = calView[63:56] == `RSP_YEAR_MAX;
    c[0] = tickGo & ~calView[8*`RSP_OFS_SEC + `RSP_STOP_BIT];
    c[1] = c[0] & w[0];
    c[2] = c[1] & w[1];
    c[3] = c[2] & w[2];
    c[4] = c[3] & w[3];
    c[5] = c[4];
    c[6] = c[5] & w[5];
    c[7] = c[6] & w[6];
    calUpd = c;
    calNext[7:0] = w[0] ? 8'h00 : incAll[7:0];
    calNext[15:8] = {calView[15], w[1] ? 7'h00 : incAll[14:8]};
    calNext[23:16] = {calView[23], w[2] ? 7'h00 : incAll[22:16]};
    calNext[31:30] = (c[7] & w[7]) ? calView[31:30] + 2'h1 : calView[31:30];
    calNext[29:24] = w[3] ? 6'h00 : incAll[29:24];
    calNext[39:32] = {calView[39:35], w[4] ? 3'h1 : calView[34:32] + 3'h1};
    calNext[47:40] = {calView[47:46], w[5] ? 6'h01 : incAll[45:40]};
    calNext[55:48] = {calView[55:53], w[6] ? 5'h01 : incAll[52:48]};
    calNext[63:56] = w[7] ? 8'h00 : incAll[63:56];
  end

  // --------------------------------------------------------------
  // register store: bytes 0-7 calendar, 8-24 control, 25-31 ram
  // --------------------------------------------------------------
  // upper half of the six-bit pointer aliases onto the 32 bytes
  rsp_reg_store #(
    .REG_COUNT(`RSP_REG_COUNT),
    .AW(`RSP_REG_AW)
  ) uStore (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .wrEn(wrStrobe),
    .wrAddr(ptr[`RSP_REG_AW-1:0]),
    .wrData(byteIn),
    .rdAddr(ptr[`RSP_REG_AW-1:0]),
    .rdData(rdData),
    .calUpd(calUpd),
    .calNext(calNext),
    .calView(calView)
  );

endmodule // rsp_serial_port

// [tb/rsp_serial_port_props.sv]
// assertion checker for the rtc serial port
`timescale 1ns/1ns
module rsp_serial_port_props (
  input wire clock, // system clock
  input wire rst_n, // async reset
  input wire clkEn, // clock enable
  input wire hundredthTick, // time tick
  input wire serialClock, // bus clock
  input wire chipSelN, // select
  input wire serial_in_line, // data in
  input wire serial_out_line, // data out
  input wire serialOutEn, // out enable
  input wire clockAccess // calendar access
);
  reg prevCs, seenFall;
  // low at release must not count as a select edge
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prevCs <= 1'b0;
      seenFall <= 1'b0;
    end else begin
      prevCs <= chipSelN;
      if (prevCs && !chipSelN) seenFall <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  desel_off_a: assert property (chipSelN |=> !serialOutEn)
    else $error("output driven while deselected");
  desel_access_a: assert property (chipSelN |-> !clockAccess)
    else $error("access while deselected");
  unarmed_quiet_a: assert property (!seenFall |-> !serialOutEn && !clockAccess)
    else $error("activity before select edge");
  cmd_quiet_a: assert property ($fell(chipSelN) |=> !serialOutEn [*8])
    else $error("output during command byte");
  fresh_cmd_a: assert property ($fell(chipSelN) |=> !clockAccess [*8])
    else $error("state kept across deselect");
  en_rise_a: assert property ($rose(serialOutEn) |-> !$past(serialClock)
    && $past(serialClock, 2)) else $error("output on without falling clock");
  out_hold_a: assert property (serialOutEn && !chipSelN && serialClock
    && $past(serialClock) |=> $stable(serial_out_line)) else $error("output moved in high phase");
  reset_out_a: assert property ($rose(rst_n) |-> !serialOutEn && !clockAccess)
    else $error("outputs not idle after reset");
  cover property ($rose(serialOutEn));
  cover property (seenFall && $fell(chipSelN));
  cover property (clockAccess);
endmodule // rsp_serial_port_props

bind rsp_serial_port rsp_serial_port_props u_props (.clock(clock), .rst_n(rst_n),
  .clkEn(clkEn), .hundredthTick(hundredthTick), .serialClock(serialClock),
  .chipSelN(chipSelN), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
  .serialOutEn(serialOutEn), .clockAccess(clockAccess));

// [tb/rsp_spi_master.sv]
// behavioural spi master facing the rtc serial port
`timescale 1ns/1ns
module rsp_spi_master (
  input wire clock, // system clock
  output reg serialClock, // bus clock
  output reg chipSelN, // select
  output reg serial_in_line, // data out
  input wire sdoPin // resolved data in
);
  reg cpol;
  integer hc;
  reg [7:0] rxByte;
  event rxDone;
  initial begin
    serialClock = 1'b0;
    chipSelN = 1'b0; // low from power-on: no select edge yet
    serial_in_line = 1'b0;
    cpol = 1'b0;
    hc = 3;
  end
  task sel;
    begin
      @(posedge clock) serialClock <= cpol;
      repeat (2) @(posedge clock);
      chipSelN <= 1'b0;
    end
  endtask
  task desel;
    begin
      @(posedge clock) chipSelN <= 1'b1;
      serial_in_line <= ~serial_in_line; // released line shows no stale bit
      serialClock <= cpol;
    end
  endtask
  // low phase of 3+ cycles so the answer settles before sampling
  task shift(input [7:0] tx, input integer nb, input reg isData);
    integer i;
    begin
      @(posedge clock);
      for (i = 7; i > 7 - nb; i = i - 1) begin
        serialClock <= 1'b0;
        serial_in_line <= tx[i];
        repeat (hc) @(posedge clock);
        serialClock <= 1'b1;
        rxByte[i] = sdoPin;
        repeat (hc) @(posedge clock);
      end
      if (isData) ->rxDone;
    end
  endtask
  task idle;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clock);
        serialClock <= ~serialClock;
        serial_in_line <= ~serial_in_line;
      end
    end
  endtask
endmodule // rsp_spi_master

// [tb/rsp_serial_port_bench.sv]
// self-checking bench for the rtc serial port
`timescale 1ns/1ns
module rsp_serial_port_bench;
  reg clock, rst_n, clkEn, hundredthTick;
  wire serialClock, chipSelN, serial_in_line, serial_out_line, serialOutEn, sdoPin, clockAccess;
  integer n_mismatch, checks, cyc, k;
  reg [7:0] mem [0:31];
  reg [7:0] expQ [$];
  reg [6:0] a;
  assign sdoPin = serialOutEn ? serial_out_line : 1'bz;
  rsp_serial_port DUT (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .hundredthTick(hundredthTick), .serialClock(serialClock), .chipSelN(chipSelN),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serialOutEn(serialOutEn), .clockAccess(clockAccess));
  rsp_spi_master m (.clock(clock), .serialClock(serialClock), .chipSelN(chipSelN),
    .serial_in_line(serial_in_line), .sdoPin(sdoPin));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task wrb(input [6:0] ad, input integer n);
    integer i;
    reg [7:0] d;
    begin
      m.sel;
      m.shift({1'b1, ad}, 8, 1'b0);
      for (i = 0; i < n; i = i + 1) begin
        d = 8'($urandom);
        m.shift(d, 8, 1'b0);
        mem[5'(ad + i)] = d;
      end
      m.desel;
    end
  endtask
  task rdb(input [6:0] ad, input integer n);
    integer i;
    begin
      m.sel;
      m.shift({1'b0, ad}, 8, 1'b0);
      for (i = 0; i < n; i = i + 1) begin
        expQ.push_back(mem[5'(ad + i)]);
        m.shift(8'($urandom), 8, 1'b1);
      end
      m.desel;
    end
  endtask
  // calendar bytes 0-7, byte i in v[8*i +: 8]
  task wrv(input [63:0] v);
    integer i;
    begin
      m.sel;
      m.shift(8'h80, 8, 1'b0);
      for (i = 0; i < 8; i = i + 1) m.shift(v[8*i +: 8], 8, 1'b0);
      m.desel;
    end
  endtask
  task setm(input [63:0] v);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) mem[i] = v[8*i +: 8];
    end
  endtask
  // one time tick; with en low the tick falls into a frozen cycle and is lost
  task tick(input reg en);
    begin
      @(posedge clock);
      clkEn <= en;
      hundredthTick <= 1'b1;
      @(posedge clock);
      clkEn <= 1'b1;
      hundredthTick <= 1'b0;
    end
  endtask
  // results arrive one byte at a time from the master
  initial begin
    forever begin
      @(m.rxDone);
      check(m.rxByte, expQ.size() ? expQ.pop_front() : 8'hXX);
    end
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  initial begin
    k = $urandom(34159);
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    hundredthTick = 1'b0;
    for (k = 0; k < 32; k = k + 1) mem[k] = (k >= 4 && k <= 6) ? 8'h01 : 8'h00;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    m.shift(8'h88, 8, 1'b0); // traffic before any select edge
    m.shift(8'h5A, 8, 1'b0);
    m.desel;
    rdb(7'h00, 9);
    m.sel;
    m.shift(8'h89, 8, 1'b0);
    m.shift(8'hFF, 4, 1'b0); // half byte must be dropped
    m.desel;
    m.idle;
    rdb(7'h09, 1);
    for (k = 0; k < 4; k = k + 1) begin
      m.cpol = k[0];
      m.hc = 3 + 3 * k[1];
      a = 7'(8 + $urandom % 24) | 7'(($urandom % 2) << 6);
      wrb(a, 4);
      rdb(a, 4);
    end
    wrb(7'h3F, 2);
    rdb(7'h1F, 2);
    // leap february, tick held while the calendar is being accessed
    wrv(64'h2402280723595999);
    m.sel;
    m.shift(8'h00, 8, 1'b0);
    @(negedge clock);
    check(8'(clockAccess), 8'h01);
    tick(1'b1);
    m.desel;
    setm(64'h2402290100000000);
    rdb(7'h00, 8);
    // year and century roll-over, one frozen tick that must not count
    wrv(64'h9912310363595999);
    tick(1'b0);
    tick(1'b1);
    setm(64'h0001010480000000);
    rdb(7'h00, 8);
    m.sel;
    m.shift(8'h08, 8, 1'b0);
    @(negedge clock);
    check(8'(clockAccess), 8'h00);
    m.desel;
    repeat (4) @(posedge clock);
    check(8'(expQ.size()), 8'h00);
    test_done;
  end
endmodule // rsp_serial_port_bench
